// ### rtl/lgc_bank.sv
// group assignment and shared colour configuration registers
`timescale 1ns/1ps
module lgc_bank
   import lgc_pkg::*;
#(
   parameter int TRIPLETS = LGC_TRIPLETS,
   parameter int CHANNELS = LGC_CHANNELS
) (
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   input  wire logic                      wr_en,
   input  wire logic                      rd_en,
   input  wire logic [7:0]                addr,
   input  wire logic [7:0]                wr_data,
   input  wire logic [CHANNELS*8-1:0]     chan_color,
   output logic      [7:0]                rd_data,
   output logic                           pattern_controller_enable,
   output logic      [CHANNELS*2-1:0]     chan_mode,
   output logic      [CHANNELS*8-1:0]     chan_color_sel
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]                pat_cfg;
      logic [7:0]                red;
      logic [7:0]                green;
      logic [7:0]                blue;
      logic [7:0]                ge_low;
      logic [7:0]                ge_high;
      logic [7:0]                rd_data;
      logic [CHANNELS*2-1:0]     mode;
      logic [CHANNELS*8-1:0]     color;
   } lgc_state_t;

   lgc_state_t st;
   lgc_state_t next_st;
   logic [TRIPLETS-1:0] ge;
   logic [23:0] shared_mix;

   // ------------------------------------------------------------------
   // per-channel mode decode
   // ------------------------------------------------------------------
   function automatic lgc_mode_t lgc_mode_of(input logic en,
                                             input logic pat);
      if (!en) begin
         return LGC_MODE_INDIVIDUAL;
      end else if (pat) begin
         return LGC_MODE_PATTERN;
      end else begin
         return LGC_MODE_GROUP;
      end
   endfunction

   always_comb begin
      next_st = st;
      ge = {st.ge_high[LGC_GE_HIGH_MSB:0], st.ge_low};
      shared_mix = {st.red, st.green, st.blue};
      if (wr_en) begin
         case (addr)
            LGC_PATTERN_CONFIG_REG_ADDR: begin
               next_st.pat_cfg = wr_data;
            end
            LGC_GROUP_RED_MIX_ADDR: begin
               next_st.red = wr_data;
            end
            LGC_GROUP_GREEN_MIX_ADDR: begin
               next_st.green = wr_data;
            end
            LGC_GROUP_BLUE_MIX_ADDR: begin
               next_st.blue = wr_data;
            end
            LGC_GROUP_ENABLE_LOW_ADDR: begin
               next_st.ge_low = wr_data;
            end
            LGC_GROUP_ENABLE_HIGH_ADDR: begin
               next_st.ge_high = wr_data & LGC_HIGH_WRITE_MASK;
            end
            default: begin
            end
         endcase
      end
      if (rd_en) begin
         case (addr)
            LGC_PATTERN_CONFIG_REG_ADDR: next_st.rd_data = st.pat_cfg;
            LGC_GROUP_RED_MIX_ADDR:      next_st.rd_data = st.red;
            LGC_GROUP_GREEN_MIX_ADDR:    next_st.rd_data = st.green;
            LGC_GROUP_BLUE_MIX_ADDR:     next_st.rd_data = st.blue;
            LGC_GROUP_ENABLE_LOW_ADDR:   next_st.rd_data = st.ge_low;
            LGC_GROUP_ENABLE_HIGH_ADDR:  next_st.rd_data = st.ge_high;
            default:                     next_st.rd_data = LGC_REG_RESET;
         endcase
      end
      for (int c = 0; c < CHANNELS; c++) begin
         next_st.mode[c*2 +: 2] =
            lgc_mode_of(ge[c/3], st.pat_cfg[LGC_PAT_EN_BIT]);
         if (ge[c/3] && !st.ge_high[LGC_COLOR_DIS_BIT]) begin
            next_st.color[c*8 +: 8] =
               shared_mix[(2-(c%3))*8 +: 8];
         end else begin
            next_st.color[c*8 +: 8] = chan_color[c*8 +: 8];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data                   = st.rd_data;
   assign pattern_controller_enable = st.pat_cfg[LGC_PAT_EN_BIT];
   assign chan_mode                 = st.mode;
   assign chan_color_sel            = st.color;
endmodule

// ### rtl/lgc_pkg.sv
// package with register map and field layout of the group colour bank
package lgc_pkg;
   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] LGC_PATTERN_CONFIG_REG_ADDR = 8'hA0;
   localparam logic [7:0] LGC_GROUP_RED_MIX_ADDR      = 8'hA8;
   localparam logic [7:0] LGC_GROUP_GREEN_MIX_ADDR    = 8'hA9;
   localparam logic [7:0] LGC_GROUP_BLUE_MIX_ADDR     = 8'hAA;
   localparam logic [7:0] LGC_GROUP_ENABLE_LOW_ADDR   = 8'hAB;
   localparam logic [7:0] LGC_GROUP_ENABLE_HIGH_ADDR  = 8'hAC;
   // ------------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------------
   localparam int         LGC_PAT_EN_BIT      = 0;
   localparam int         LGC_COLOR_DIS_BIT   = 4;
   localparam int         LGC_GE_HIGH_MSB     = 3;
   localparam logic [7:0] LGC_REG_RESET       = 8'h00;
   localparam logic [7:0] LGC_HIGH_WRITE_MASK = 8'h1F;
   localparam int         LGC_TRIPLETS        = 12;
   localparam int         LGC_CHANNELS        = 36;
   localparam int         LGC_COLOR_W         = 8;
   typedef enum logic [1:0] {
      LGC_MODE_INDIVIDUAL,
      LGC_MODE_GROUP,
      LGC_MODE_PATTERN
   } lgc_mode_t;
endpackage

// ### testbench/lgc_bank_monitor.sv
// checker of the group colour bank ports
`timescale 1ns/1ps
module lgc_bank_monitor (
   input wire logic         clk,
   input wire logic         rst_b,
   input wire logic         wr_en,
   input wire logic         rd_en,
   input wire logic [7:0]   addr,
   input wire logic [7:0]   wr_data,
   input wire logic [287:0] chan_color,
   input wire logic [7:0]   rd_data,
   input wire logic         pattern_controller_enable,
   input wire logic [71:0]  chan_mode,
   input wire logic [287:0] chan_color_sel
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_blue_rdback: assert property (wr_en && addr == 8'hAA ##1 rd_en &&
      !wr_en && addr == 8'hAA |=> rd_data == $past(wr_data, 2))
      else $error("blue readback");
   a_red_rdback: assert property (wr_en && addr == 8'hA8 ##1 rd_en &&
      !wr_en && addr == 8'hA8 |=> rd_data == $past(wr_data, 2))
      else $error("red readback");
   a_high_mask: assert property (rd_en && addr == 8'hAC
      |=> rd_data[7:5] == 3'h0) else $error("reserved bits set");
   a_mode_pat: assert property ((!wr_en)[*3] |=> chan_mode[1:0] !=
      (pattern_controller_enable ? 2'h1 : 2'h2)) else $error("mode vs enable");
   a_triplet_eq: assert property (chan_mode[5:0] inside
      {6'h00, 6'h15, 6'h2A}) else $error("triplet split");
   a_hi_triplet: assert property (chan_mode[71:66] inside
      {6'h00, 6'h15, 6'h2A}) else $error("high triplet split");
   a_indiv_col: assert property ((!wr_en)[*4] |-> chan_mode[1:0] != 2'h0
      || chan_color_sel[7:0] == $past(chan_color[7:0])) else $error("own colour");
   a_pat_rd: assert property (rd_en && addr == 8'hA0 && !wr_en
      |=> rd_data[0] == pattern_controller_enable) else $error("enable readback");
endmodule
bind lgc_bank lgc_bank_monitor i_mon (.*);

// ### testbench/lgc_bank_tb_top.sv
// self-checking bench of the group colour bank
`timescale 1ns/1ps
module lgc_bank_tb_top;
   logic         clk = 1'b0;
   logic         rst_b = 1'b0;
   logic         wr_en, rd_en, pat;
   logic [7:0]   addr, wr_data, rd_data, d, a;
   logic [71:0]  mode;
   logic [287:0] col, sel;
   int           n_mismatch = 0;
   int           n_checks = 0;
   always #4 clk = ~clk;
   lgc_bank i_dut (.clk(clk), .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wr_data(wr_data), .chan_color(col), .rd_data(rd_data),
      .pattern_controller_enable(pat), .chan_mode(mode), .chan_color_sel(sel));
   lgc_host i_host (.clk(clk), .rd_data(rd_data), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wr_data(wr_data));
   task chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task st;
      i_host.idle();
      repeat (3) @(posedge clk);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      for (int c = 0; c < 36; c++) col[c*8+:8] = 8'h40 + 8'(c);
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      for (a = 8'hA8; a < 8'hAD; a++) begin
         i_host.rd(a, d);
         chk(d, 8'h00);
      end
      for (a = 8'hA8; a < 8'hAB; a++) begin
         i_host.wr(a, a ^ 8'h5A);
         i_host.rd(a, d);
         chk(d, a ^ 8'h5A);
      end
      i_host.rd(8'hB0, d);
      chk(d, 8'h00);
      i_host.wr(8'hAB, 8'h01);
      i_host.wr(8'hAC, 8'hE8);
      i_host.rd(8'hAC, d);
      chk(d, 8'h08);
      st();
      chk(8'(mode[5:0]), 8'h15);
      chk(8'(mode[71:66]), 8'h15);
      chk(8'(mode[11:6]), 8'h00);
      chk(sel[7:0], 8'hF2);
      chk(sel[15:8], 8'hF3);
      chk(sel[287:280], 8'hF0);
      chk(sel[31:24], 8'h43);
      i_host.wr(8'hAC, 8'h18);
      st();
      chk(sel[287:280], 8'h63);
      chk(sel[7:0], 8'h40);
      i_host.wr(8'hA0, 8'h01);
      st();
      chk(8'(mode[5:0]), 8'h2A);
      chk(8'(pat), 8'h01);
      i_host.rd(8'hA0, d);
      chk(d, 8'h01);
      wrap_up();
   end
endmodule

// ### testbench/lgc_host.sv
// host model issuing register writes and reads
`timescale 1ns/1ps
module lgc_host (
   input  wire logic       clk,
   input  wire logic [7:0] rd_data,
   output logic            wr_en = 1'b0,
   output logic            rd_en = 1'b0,
   output logic      [7:0] addr = 8'h00,
   output logic      [7:0] wr_data = 8'h00
);
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {wr_en, rd_en, addr, wr_data} <= {2'b10, a, d};
   endtask
   task idle;
      @(posedge clk);
      {wr_en, rd_en, addr, wr_data} <= {2'b00, ~addr, ~wr_data};
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      {wr_en, rd_en, addr} <= {2'b01, a};
      @(posedge clk);
      {rd_en, addr} <= {1'b0, ~a};
      @(negedge clk);
      d = rd_data;
   endtask
endmodule
